// file: logic/sci_checker.sv
// spindle command interlock checker: apb config, command checks, error latch
`timescale 1ns/100ps

// Function
// - run refused under estop or missing ready
// - hires coder, separate motor needs 128 ppr
// - contouring needs hires coder configured
// - servo or sync needs position coder
// - orientation needs orientation option
// - low winding needs switchover option
// - contouring, servo and sync need a run command
// - exclusive modes, error keyed to active
// - forward and reverse together is error
// - contouring refused with differential enabled
// - differential command needs differential enabled
// - detector selection must name fitted detector
// - coder orientation needs position coder
// - magnetic orientation blocks other modes
// - follower and hires coder conflict
// - follower entry refused in position control
// - position control refused while following
// - follower command needs follower enabled
// - incremental then absolute indexing is error
// - open estop contact means emergency stop
module sci_checker
   import sci_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire sci_cmd_s    i_cmd,
   input  wire logic        i_estop_contact_closed,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic      [4:0]  o_err_code,
   output logic             o_err_valid,
   output logic             o_excite_inhibit
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] cfg;
      sci_cmd_s    cmd_m;
      sci_cmd_s    cmd;
      logic        esc_m;
      logic        esc;
      sci_mode_e   mode;
      logic        follow_act;
      logic        inc_done;
      logic        follow_prev;
      logic [4:0]  code;
      logic        valid;
      logic        inhibit;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } sci_state_s;

   sci_state_s s_q;
   sci_state_s s_d;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic is_reg(input logic [11:0] a);
      is_reg = (a == SCI_CFG_OFS) || (a == SCI_CMD_OFS) ||
               (a == SCI_STAT_OFS) || (a == SCI_CLR_OFS);
   endfunction : is_reg

   function automatic sci_mode_e req_mode(input sci_cmd_s c);
      if (c.cs_contour_cmd)
         req_mode = SCI_M_CS;
      else if (c.servo_mode_cmd)
         req_mode = SCI_M_SERVO;
      else if (c.sync_ctrl_cmd)
         req_mode = SCI_M_SYNC;
      else if (c.orient_cmd)
         req_mode = SCI_M_ORIENT;
      else
         req_mode = SCI_M_IDLE;
   endfunction : req_mode

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic       acc;
   logic [3:0] nmodes;
   logic       any_run;
   logic       estop;
   logic       hires;
   logic       pcoder;
   logic       ferr;
   logic [4:0] fcode;
   logic [2:0] det_sel;
   sci_cmd_s   c;

   always_comb
   begin
      s_d = s_q;
      c = s_q.cmd;
      acc = i_psel && i_penable;
      hires = s_q.cfg[CFG_HIRES_BIT];
      pcoder = s_q.cfg[CFG_PCODER_BIT];
      det_sel = s_q.cfg[CFG_DET_SEL_LSB +: 3];
      nmodes = {3'h0, c.cs_contour_cmd} + {3'h0, c.servo_mode_cmd} +
               {3'h0, c.sync_ctrl_cmd} + {3'h0, c.orient_cmd};
      any_run = c.run_forward_cmd || c.run_reverse_cmd;
      // both contact and host signal must show normal operation
      estop = !s_q.esc || !c.emergency_stop_n;
      ferr = 1'b1;
      fcode = 5'h00;

      // input synchronisers; first stage read only by the second
      s_d.cmd_m = i_cmd;
      s_d.cmd = s_q.cmd_m;
      s_d.esc_m = i_estop_contact_closed;
      s_d.esc = s_q.esc_m;
      s_d.follow_prev = c.follower_mode_cmd;

      // priority: configuration faults first, then sequence faults
      if (hires && !s_q.cfg[CFG_INTEG_BIT] &&
          s_q.cfg[CFG_DET_PPR_LSB +: CFG_DET_PPR_W] != PPR_REQUIRED)
         fcode = SCI_ER_02;
      else if (det_sel > DET_SEL_MAX)
         fcode = SCI_ER_17;
      else if (s_q.cfg[CFG_FOLLOW_EN_BIT] && hires)
         fcode = SCI_ER_20;
      else if (c.run_forward_cmd && c.run_reverse_cmd)
         fcode = SCI_ER_14;
      else if (any_run && (estop || (s_q.cfg[CFG_MACHINE_READY_USE_BIT] && !c.machine_ready)))
         fcode = SCI_ER_01;
      else if (nmodes > 4'h1 && s_q.mode != SCI_M_IDLE)
      begin
         // host is expected to release first; catch it when it does not
         unique case (s_q.mode)
            SCI_M_CS:     fcode = SCI_ER_10;
            SCI_M_SERVO:  fcode = SCI_ER_11;
            SCI_M_SYNC:   fcode = SCI_ER_12;
            SCI_M_ORIENT: fcode = c.orient_pcoder_type ? SCI_ER_13 : SCI_ER_19;
            default:      fcode = SCI_ER_10;
         endcase
      end
      else if (c.cs_contour_cmd && !hires)
         fcode = SCI_ER_03;
      else if (c.cs_contour_cmd && s_q.cfg[CFG_DIFF_EN_BIT])
         fcode = SCI_ER_15;
      else if ((c.servo_mode_cmd || c.sync_ctrl_cmd) && !pcoder)
         fcode = SCI_ER_04;
      else if (c.orient_cmd && !s_q.cfg[CFG_ORIENT_OPT_BIT])
         fcode = SCI_ER_05;
      else if (c.orient_cmd && c.orient_pcoder_type && !pcoder)
         fcode = SCI_ER_18;
      else if (c.low_winding_sel && !s_q.cfg[CFG_SWOVER_OPT_BIT])
         fcode = SCI_ER_06;
      else if (c.cs_contour_cmd && !any_run)
         fcode = SCI_ER_07;
      else if (c.servo_mode_cmd && !any_run)
         fcode = SCI_ER_08;
      else if (c.sync_ctrl_cmd && !any_run)
         fcode = SCI_ER_09;
      else if (c.differential_mode_cmd && !s_q.cfg[CFG_DIFF_EN_BIT])
         fcode = SCI_ER_16;
      else if (c.follower_mode_cmd && !s_q.cfg[CFG_FOLLOW_EN_BIT])
         fcode = SCI_ER_23;
      // follower never gained while in position control, so the fault stands until release
      else if (c.follower_mode_cmd && !s_q.follow_act &&
               (s_q.mode == SCI_M_SERVO || s_q.mode == SCI_M_ORIENT))
         fcode = SCI_ER_21;
      else if (s_q.follow_act && !s_q.follow_prev &&
               (c.servo_mode_cmd || c.orient_cmd))
         fcode = SCI_ER_22;
      else if (s_q.follow_act && (c.servo_mode_cmd || c.orient_cmd) &&
               s_q.mode == SCI_M_IDLE)
         fcode = SCI_ER_22;
      else if (c.orient_cmd && c.orient_pcoder_type && s_q.inc_done &&
               !c.incremental_move_sel)
         fcode = SCI_ER_24;
      else
         ferr = 1'b0;

      // mode tracking: accept a single mode only when fault free
      if (nmodes == 4'h0)
         s_d.mode = SCI_M_IDLE;
      else if (s_q.mode == SCI_M_IDLE && !ferr)
         s_d.mode = req_mode(c);

      s_d.follow_act = c.follower_mode_cmd && (s_q.follow_act || !ferr);

      // incremental history kept across indexing steps while coder orientation is selected
      if (!c.orient_pcoder_type)
         s_d.inc_done = 1'b0;
      else if (c.orient_cmd && c.incremental_move_sel)
         s_d.inc_done = 1'b1;

      // error latch: a new fault wins over a software clear
      if (ferr)
      begin
         s_d.code = fcode;
         s_d.valid = 1'b1;
      end
      else if (acc && s_q.pready && i_pwrite && i_paddr == SCI_CLR_OFS && i_pwdata[0])
      begin
         s_d.code = SCI_ER_NONE;
         s_d.valid = 1'b0;
      end
      // inhibit follows the live condition, not the sticky code
      s_d.inhibit = ferr;

      // apb slave: one wait state, ready in the second access cycle
      s_d.pready = acc && !s_q.pready;
      s_d.pslverr = acc && !s_q.pready && !is_reg(i_paddr);
      s_d.prdata = 32'h0000_0000;
      // writes land only at the edge that sees ready high
      if (acc && s_q.pready && i_pwrite && i_paddr == SCI_CFG_OFS)
         s_d.cfg = i_pwdata;
      if (acc && !s_q.pready)
      begin
         if (!i_pwrite)
         begin
            unique case (i_paddr)
               SCI_CFG_OFS:  s_d.prdata = s_q.cfg;
               SCI_CMD_OFS:  s_d.prdata = {19'h0, s_q.cmd};
               SCI_STAT_OFS: s_d.prdata = {21'h0, s_q.follow_act, s_q.mode,
                                           s_q.inhibit, s_q.valid, s_q.code[4:0]};
               default:      s_d.prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_q <= '0;
         s_q.cfg <= CFG_RESET;
      end
      else
         s_q <= s_d;
   end

   assign o_prdata = s_q.prdata;
   assign o_pready = s_q.pready;
   assign o_pslverr = s_q.pslverr;
   assign o_err_code = s_q.code;
   assign o_err_valid = s_q.valid;
   assign o_excite_inhibit = s_q.inhibit;

endmodule : sci_checker

// file: logic/sci_pkg.sv
// package: register map, config layout, error codes for the spindle interlock checker
package sci_pkg;

   // ----------------------------------------
   // apb register map
   // ----------------------------------------
   localparam logic [11:0] SCI_CFG_OFS    = 12'h000;
   localparam logic [11:0] SCI_CMD_OFS    = 12'h004;
   localparam logic [11:0] SCI_STAT_OFS   = 12'h008;
   localparam logic [11:0] SCI_CLR_OFS    = 12'h00C;

   // ----------------------------------------
   // config register field positions
   // ----------------------------------------
   localparam int CFG_MACHINE_READY_USE_BIT   = 0;
   localparam int CFG_HIRES_BIT      = 1;
   localparam int CFG_INTEG_BIT      = 2;
   localparam int CFG_PCODER_BIT     = 3;
   localparam int CFG_ORIENT_OPT_BIT = 4;
   localparam int CFG_SWOVER_OPT_BIT = 5;
   localparam int CFG_DIFF_EN_BIT    = 6;
   localparam int CFG_FOLLOW_EN_BIT  = 7;
   localparam int CFG_DET_SEL_LSB    = 8;
   localparam int CFG_DET_PPR_LSB    = 16;
   localparam int CFG_DET_PPR_W      = 16;

   localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
   localparam logic [15:0] PPR_REQUIRED   = 16'h0080;
   // detector selection codes that name a fitted detector (low four codes)
   localparam logic [2:0]  DET_SEL_MAX    = 3'h3;

   // ----------------------------------------
   // sequence error codes
   // ----------------------------------------
   typedef enum logic [4:0] {
      SCI_ER_NONE = 5'h00, SCI_ER_01 = 5'h01, SCI_ER_02 = 5'h02, SCI_ER_03 = 5'h03,
      SCI_ER_04 = 5'h04, SCI_ER_05 = 5'h05, SCI_ER_06 = 5'h06, SCI_ER_07 = 5'h07,
      SCI_ER_08 = 5'h08, SCI_ER_09 = 5'h09, SCI_ER_10 = 5'h0A, SCI_ER_11 = 5'h0B,
      SCI_ER_12 = 5'h0C, SCI_ER_13 = 5'h0D, SCI_ER_14 = 5'h0E, SCI_ER_15 = 5'h0F,
      SCI_ER_16 = 5'h10, SCI_ER_17 = 5'h11, SCI_ER_18 = 5'h12, SCI_ER_19 = 5'h13,
      SCI_ER_20 = 5'h14, SCI_ER_21 = 5'h15, SCI_ER_22 = 5'h16, SCI_ER_23 = 5'h17,
      SCI_ER_24 = 5'h18
   } sci_err_e;

   // active exclusive mode
   typedef enum logic [2:0] {
      SCI_M_IDLE   = 3'b000,
      SCI_M_CS     = 3'b001,
      SCI_M_SERVO  = 3'b010,
      SCI_M_SYNC   = 3'b011,
      SCI_M_ORIENT = 3'b100
   } sci_mode_e;

   // host command inputs
   typedef struct packed {
      logic run_forward_cmd;
      logic run_reverse_cmd;
      logic cs_contour_cmd;
      logic servo_mode_cmd;
      logic sync_ctrl_cmd;
      logic orient_cmd;
      logic orient_pcoder_type;
      logic differential_mode_cmd;
      logic follower_mode_cmd;
      logic incremental_move_sel;
      logic low_winding_sel;
      logic machine_ready;
      logic emergency_stop_n;
   } sci_cmd_s;

endpackage : sci_pkg

// file: testbench/sci_checker_monitor.sv
// assertion checker on the spindle interlock checker ports
`timescale 1ns/100ps
module sci_checker_monitor
   import sci_pkg::*;
(
   input wire logic        i_ref_clk,
   input wire logic        i_rst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire sci_cmd_s    i_cmd,
   input wire logic        i_estop_contact_closed,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic [4:0]  o_err_code,
   input wire logic        o_err_valid,
   input wire logic        o_excite_inhibit
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   logic clr_w;
   assign clr_w = i_psel & i_penable & i_pwrite & (i_paddr == SCI_CLR_OFS) & i_pwdata[0];
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   answer_one_wait_a: assert property (i_psel && $rose(i_penable) |=> o_pready)
      else $error("pready not after one wait");
   ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready held");
   slverr_ready_a: assert property (o_pslverr |-> o_pready) else $error("pslverr alone");
   unmapped_refused_a: assert property (o_pready && i_paddr[11:4] != 8'h00
      |-> o_pslverr && o_prdata == 32'h0) else $error("unmapped access accepted");
   clear_cause_a: assert property ($fell(o_err_valid) |-> $past(clr_w) || $past(clr_w, 2))
      else $error("valid dropped without clear");
   code_valid_pair_a: assert property (o_err_valid == (o_err_code != 5'h00))
      else $error("code and valid disagree");
   run_estop_a: assert property ((i_cmd.run_forward_cmd && !i_cmd.emergency_stop_n) [*5]
      |-> o_excite_inhibit && o_err_valid) else $error("run accepted in estop");
   contact_open_a: assert property ((!i_estop_contact_closed && i_cmd.run_forward_cmd) [*5]
      |-> o_excite_inhibit) else $error("run accepted with contact open");
   both_dirs_a: assert property ((i_cmd.run_forward_cmd && i_cmd.run_reverse_cmd) [*5]
      |-> o_excite_inhibit) else $error("both directions accepted");
   mode_no_run_a: assert property (((i_cmd.cs_contour_cmd || i_cmd.servo_mode_cmd
      || i_cmd.sync_ctrl_cmd) && !i_cmd.run_forward_cmd && !i_cmd.run_reverse_cmd) [*5]
      |-> o_excite_inhibit) else $error("mode accepted without run");
endmodule : sci_checker_monitor

// file: testbench/sci_host_model.sv
// host command model driving the interlock checker inputs
`timescale 1ns/100ps
module sci_host_model
   import sci_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic [13:0] i_next,
   output sci_cmd_s         o_cmd,
   output logic             o_contact_closed
);
   // ----------------------------------------
   // levels change only just after an edge
   // ----------------------------------------
   // bit 13 opens the contact, bits 1:0 drop ready and estop_n: zero is a quiet host
   always_ff @(posedge i_ref_clk)
   begin
      {o_contact_closed, o_cmd} <= i_next ^ 14'h2003;
   end
endmodule : sci_host_model

// file: testbench/tb_top.sv
// self-checking bench for the spindle interlock checker
`timescale 1ns/100ps
module tb_top
   import sci_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [13:0] cmd_next = 14'h0;
   sci_cmd_s    cmd;
   logic        contact, pready, pslverr, valid, inhib, e;
   logic [4:0]  code;
   int          err_count = 0, samples_checked = 0;
   sci_host_model sci_host_model_i (.i_ref_clk(clk), .i_next(cmd_next), .o_cmd(cmd),
      .o_contact_closed(contact));
   sci_checker sci_checker_i (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_cmd(cmd),
      .i_estop_contact_closed(contact), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_err_code(code), .o_err_valid(valid), .o_excite_inhibit(inhib));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         err_count++;
   endtask : apb
   // pre sets up an accepted mode first, so codes keyed to the active mode can be reached
   task automatic rc(input logic [31:0] c, input logic [13:0] pre, input logic [13:0] cm,
                     input logic [4:0] ec);
      apb(1'b1, SCI_CFG_OFS, c);
      cmd_next <= pre;
      repeat (6) @(posedge clk);
      cmd_next <= cm;
      repeat (6) @(posedge clk);
      chk({26'h0, inhib, code}, {26'h1, ec});
      apb(1'b0, SCI_STAT_OFS, 32'h0);
      chk({25'h0, r[6:0]}, {25'h0, 2'b11, ec});
      cmd_next <= 14'h0;
      apb(1'b1, SCI_CFG_OFS, 32'h0);
      // wait out the input sync so the clear is not beaten by the old fault
      repeat (6) @(posedge clk);
      apb(1'b1, SCI_CLR_OFS, 32'h1);
      repeat (4) @(posedge clk);
      chk({30'h0, valid, inhib}, 32'h0);
      $display("case code %0d done", ec);
   endtask : rc
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      forever #5 clk = ~clk;
   end
   // whole run is under 2000 cycles, so 10000 cycles means a hang
   initial
   begin
      #100000;
      err_count++;
      end_of_test;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, SCI_CFG_OFS, 32'h0);
      chk(r, CFG_RESET);
      apb(1'b1, SCI_CFG_OFS, 32'h0080_0006);
      apb(1'b0, SCI_CFG_OFS, 32'h0);
      chk(r, 32'h0080_0006);
      apb(1'b0, 12'h010, 32'h0);
      chk({r[30:0], e}, 32'h1);
      rc(32'h0, 14'h0, 14'h1001, SCI_ER_01);
      rc(32'h1, 14'h0, 14'h1002, SCI_ER_01);
      rc(32'h0, 14'h0, 14'h3000, SCI_ER_01);
      rc(32'h2, 14'h0, 14'h0000, SCI_ER_02);
      rc(32'h0, 14'h0, 14'h1400, SCI_ER_03);
      rc(32'h0, 14'h0, 14'h1200, SCI_ER_04);
      rc(32'h0, 14'h0, 14'h0080, SCI_ER_05);
      rc(32'h0, 14'h0, 14'h0004, SCI_ER_06);
      rc(32'h6, 14'h0, 14'h0400, SCI_ER_07);
      rc(32'h8, 14'h0, 14'h0200, SCI_ER_08);
      rc(32'h8, 14'h0, 14'h0100, SCI_ER_09);
      rc(32'h6, 14'h1400, 14'h1500, SCI_ER_10);
      rc(32'h8, 14'h1200, 14'h1600, SCI_ER_11);
      rc(32'h8, 14'h1100, 14'h1300, SCI_ER_12);
      rc(32'h18, 14'h00C0, 14'h02C0, SCI_ER_13);
      rc(32'h0, 14'h0, 14'h1800, SCI_ER_14);
      rc(32'h46, 14'h0, 14'h1400, SCI_ER_15);
      rc(32'h0, 14'h0, 14'h0020, SCI_ER_16);
      rc(32'h400, 14'h0, 14'h0000, SCI_ER_17);
      rc(32'h10, 14'h0, 14'h00C0, SCI_ER_18);
      rc(32'h18, 14'h0080, 14'h0180, SCI_ER_19);
      rc(32'h86, 14'h0, 14'h0000, SCI_ER_20);
      rc(32'h88, 14'h1200, 14'h1210, SCI_ER_21);
      rc(32'h88, 14'h0010, 14'h1210, SCI_ER_22);
      rc(32'h0, 14'h0, 14'h0010, SCI_ER_23);
      rc(32'h18, 14'h00C8, 14'h00C0, SCI_ER_24);
      end_of_test;
   end
endmodule : tb_top
bind sci_checker sci_checker_monitor sci_checker_monitor_i (.i_ref_clk(i_ref_clk),
   .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_cmd(i_cmd),
   .i_estop_contact_closed(i_estop_contact_closed), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_err_code(o_err_code), .o_err_valid(o_err_valid),
   .o_excite_inhibit(o_excite_inhibit));
